/* uft_flow_timing.v */
// Transmit timing, interrupts, DMA ready, modem outputs and auto-RTS.
// Assumes all inputs are synchronous to mclk_i and strobes last one cycle.
`timescale 1ns/1ps
`default_nettype none
`include "uft_defines.vh"
module uft_flow_timing #(
  parameter [15:0] BAUD_DIVISOR = 16'd4
) (
  input wire mclk_i,
  input wire rst_b_i,
  input wire thr_write_i,
  input wire [7:0] thr_data_i,
  input wire iir_read_i,
  input wire msr_read_i,
  input wire mcr_write_i,
  input wire [3:0] mcr_data_i,
  input wire [3:0] modem_in_i,
  input wire fifo_enable_bit_i,
  input wire dma_mode_bit_i,
  input wire auto_rts_en_i,
  input wire [1:0] rx_trigger_i,
  input wire [4:0] rx_level_i,
  input wire rx_byte_done_i,
  input wire rx_first_data_bit_i,
  input wire rx_buffer_read_i,
  input wire rx_data_event_i,
  input wire rx_timeout_i,
  input wire rclk_tick_i,
  output reg serial_out_o,
  output reg interrupt_out_o,
  output reg tx_dma_request_n_o,
  output reg rx_dma_request_n_o,
  output reg rts_n_o,
  output reg dtr_n_o,
  output reg out1_n_o,
  output reg out2_n_o
);
  localparam [1:0] TX_IDLE = 2'd0, TX_WAIT = 2'd1, TX_SEND = 2'd2;
  // Receive trigger code to byte count
  function [4:0] trig_level;
    input [1:0] code;
    begin
      case (code)
        `UFT_TRIG_1: trig_level = 5'd1;
        `UFT_TRIG_4: trig_level = 5'd4;
        `UFT_TRIG_8: trig_level = 5'd8;
        default: trig_level = 5'd14;
      endcase
    end
  endfunction

  wire baud_tick, mode1, auto_rts, start_now, rx_need;
  reg [1:0] tx_state_q;
  reg [4:0] wait_cnt_q, post_cnt_q;
  reg [3:0] bit_tick_q, bit_cnt_q, modem_prev_q, rx_cnt_q, mcr_q;
  reg [8:0] shift_q;
  reg [7:0] hold_q;
  reg post_run_q, hold_full_q, tx_holding_empty_pend_q, tx_dma_request_q, msr_pend_q;
  reg rx_pend_q, rx_armed_q, rts_hold_q, modem_seen_q;
  // Write data is forwarded so the modem pins follow in one clock
  wire [3:0] mcr_now = mcr_write_i ? mcr_data_i : mcr_q;
  uft_baud_gen #(.DIVISOR(BAUD_DIVISOR)) u_baud (.mclk_i(mclk_i),
    .rst_b_i(rst_b_i), .tick_o(baud_tick));
  assign mode1 = fifo_enable_bit_i & dma_mode_bit_i;
  assign auto_rts = fifo_enable_bit_i & auto_rts_en_i;
  assign start_now = (tx_state_q == TX_WAIT) & baud_tick &
                     (wait_cnt_q == `UFT_START_TICKS - 5'd1);
  // Holding register: full on write, emptied when the start bit begins
  always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hold_q <= 8'h00;
      hold_full_q <= 1'b0;
    end else if (thr_write_i) begin
      hold_q <= thr_data_i;
      hold_full_q <= 1'b1;
    end else if (start_now) begin
      hold_full_q <= 1'b0;
    end
  end
  // Transmit sequencer; the wait fixes start at 16 ticks after a write
  always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_state_q <= TX_IDLE;
      wait_cnt_q <= 5'd0;
      bit_tick_q <= 4'd0;
      bit_cnt_q <= 4'd0;
      shift_q <= 9'h1ff;
      serial_out_o <= 1'b1;
    end else begin
      case (tx_state_q)
        TX_IDLE: begin
          serial_out_o <= 1'b1;
          wait_cnt_q <= 5'd0;
          if (hold_full_q || thr_write_i) begin
            tx_state_q <= TX_WAIT;
          end
        end
        TX_WAIT: begin
          if (start_now) begin
            serial_out_o <= 1'b0;
            shift_q <= {1'b1, hold_q};
            bit_tick_q <= 4'd0;
            bit_cnt_q <= 4'd0;
            tx_state_q <= TX_SEND;
          end else if (baud_tick) begin
            wait_cnt_q <= wait_cnt_q + 5'd1;
          end
        end
        TX_SEND: begin
          if (baud_tick) begin
            if (bit_tick_q == `UFT_BIT_TICKS) begin
              bit_tick_q <= 4'd0;
              if (bit_cnt_q == `UFT_FRAME_BITS) begin
                serial_out_o <= 1'b1;
                tx_state_q <= TX_IDLE;
              end else begin
                // LSB first, stop bit shifts in behind the data
                serial_out_o <= shift_q[0];
                shift_q <= {1'b1, shift_q[8:1]};
                bit_cnt_q <= bit_cnt_q + 4'd1;
              end
            end else begin
              bit_tick_q <= bit_tick_q + 4'd1;
            end
          end
        end
        default: begin
          tx_state_q <= TX_IDLE;
        end
      endcase
    end
  end
  // Ticks since start bit, drives holding-empty and DMA ready timing
  always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      post_cnt_q <= 5'd0;
      post_run_q <= 1'b0;
    end else if (start_now) begin
      post_cnt_q <= 5'd0;
      post_run_q <= 1'b1;
    end else if (post_run_q && baud_tick) begin
      post_cnt_q <= post_cnt_q + 5'd1;
      if (post_cnt_q == `UFT_TX_HOLDING_EMPTY_TICKS - 5'd1) begin
        post_run_q <= 1'b0;
      end
    end
  end
  // Holding-empty pending; a new write both clears and blocks the set
  always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_holding_empty_pend_q <= 1'b0;
    end else if (post_run_q && baud_tick &&
                 post_cnt_q == `UFT_TX_HOLDING_EMPTY_TICKS - 5'd1 &&
                 !hold_full_q && !thr_write_i) begin
      tx_holding_empty_pend_q <= 1'b1;
    end else if (thr_write_i) begin
      tx_holding_empty_pend_q <= 1'b0;
    end else if (iir_read_i) begin
      tx_holding_empty_pend_q <= 1'b0;
    end
  end
  // Transmit ready: dropped by a write, restored 8 ticks after start
  always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_dma_request_q <= 1'b1;
    end else if (thr_write_i) begin
      tx_dma_request_q <= 1'b0;
    end else if (post_run_q && baud_tick &&
                 post_cnt_q == `UFT_TX_DMA_REQUEST_TICKS - 5'd1) begin
      tx_dma_request_q <= 1'b1;
    end
  end
  // Modem status change detect; set wins over the read clear
  // First clock after reset only primes the sample: no false change
  always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      modem_prev_q <= 4'h0;
      msr_pend_q <= 1'b0;
      modem_seen_q <= 1'b0;
    end else begin
      modem_prev_q <= modem_in_i;
      modem_seen_q <= 1'b1;
      if (modem_seen_q && modem_in_i != modem_prev_q) begin
        msr_pend_q <= 1'b1;
      end else if (msr_read_i) begin
        msr_pend_q <= 1'b0;
      end
    end
  end
  // Receive interrupt delay counted in reference ticks: 1 or 9
  always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_cnt_q <= 4'd0;
      rx_armed_q <= 1'b0;
      rx_pend_q <= 1'b0;
    end else begin
      if (rx_data_event_i) begin
        rx_cnt_q <= `UFT_RX_IRQ_TICKS;
        rx_armed_q <= 1'b1;
      end else if (rx_timeout_i) begin
        rx_cnt_q <= `UFT_TMO_IRQ_TICKS;
        rx_armed_q <= 1'b1;
      end else if (rx_armed_q && rclk_tick_i) begin
        rx_cnt_q <= rx_cnt_q - 4'd1;
        if (rx_cnt_q == 4'd1) begin
          rx_armed_q <= 1'b0;
        end
      end
      if (rx_armed_q && rclk_tick_i && rx_cnt_q == 4'd1) begin
        rx_pend_q <= 1'b1;
      end else if (rx_buffer_read_i) begin
        rx_pend_q <= 1'b0;
      end
    end
  end
  // Single interrupt output from all pending sources
  always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      interrupt_out_o <= 1'b0;
    end else begin
      interrupt_out_o <= tx_holding_empty_pend_q | msr_pend_q | rx_pend_q;
    end
  end
  // Mode 0 follows holder or one byte; mode 1 follows trigger level or pending receive interrupt
  assign rx_need = mode1 ? (rx_level_i >= trig_level(rx_trigger_i)) |
                           rx_pend_q : (rx_level_i != 5'd0);
  always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_dma_request_n_o <= 1'b1;
      rx_dma_request_n_o <= 1'b1;
    end else begin
      tx_dma_request_n_o <= ~(tx_dma_request_q & ~thr_write_i);
      rx_dma_request_n_o <= ~rx_need;
    end
  end
  // Modem control register; pins update on the same clock edge as the register
  always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mcr_q <= 4'h0;
    end else if (mcr_write_i) begin
      mcr_q <= mcr_data_i;
    end
  end
  // Auto-RTS hold: set on the strobe's clock edge; rts_n_o follows one clock later
  always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rts_hold_q <= 1'b0;
    end else if (!auto_rts) begin
      rts_hold_q <= 1'b0;
    end else if (rx_trigger_i != `UFT_TRIG_14 && rx_byte_done_i &&
                 rx_level_i + 5'd1 >= trig_level(rx_trigger_i)) begin
      rts_hold_q <= 1'b1;
    end else if (rx_trigger_i == `UFT_TRIG_14 && rx_first_data_bit_i &&
                 rx_level_i == `UFT_LEVEL_FULL15) begin
      rts_hold_q <= 1'b1;
    end else if (rx_buffer_read_i && rx_level_i == 5'd1) begin
      rts_hold_q <= 1'b0;
    end
  end
  // Modem pins, active low; write data is forwarded so no extra delay
  always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rts_n_o <= 1'b1;
      dtr_n_o <= 1'b1;
      out1_n_o <= 1'b1;
      out2_n_o <= 1'b1;
    end else begin
      rts_n_o <= ~(mcr_now[`UFT_MCR_RTS] & ~rts_hold_q);
      dtr_n_o <= ~mcr_now[`UFT_MCR_DTR];
      out1_n_o <= ~mcr_now[`UFT_MCR_OUT1];
      out2_n_o <= ~mcr_now[`UFT_MCR_OUT2];
    end
  end
endmodule // uft_flow_timing
`default_nettype wire

/* uft_defines.vh */
// Constants for the serial element timing and flow-control block.
// Assumes counts are in baud ticks (16x clock) or receiver reference ticks.
`ifndef UFT_DEFINES_VH
`define UFT_DEFINES_VH
// Baud ticks from holding write to start bit (allowed 8..24)
`define UFT_START_TICKS 5'd16
// Baud ticks from start bit to holding-empty interrupt (allowed 8..10)
`define UFT_TX_HOLDING_EMPTY_TICKS 5'd9
// Baud ticks from start bit to transmit-ready active (at most 9)
`define UFT_TX_DMA_REQUEST_TICKS 5'd8
// Last baud tick count of a serial bit; a bit lasts 16 ticks
`define UFT_BIT_TICKS 4'd15
// Bits shifted out after the start bit: 8 data, stop
`define UFT_FRAME_BITS 4'd9
// Receiver reference ticks for normal and timeout interrupts
`define UFT_RX_IRQ_TICKS 4'd1
`define UFT_TMO_IRQ_TICKS 4'd9
// Receive trigger codes
`define UFT_TRIG_1 2'b00
`define UFT_TRIG_4 2'b01
`define UFT_TRIG_8 2'b10
`define UFT_TRIG_14 2'b11
// Modem control bit positions
`define UFT_MCR_DTR 0
`define UFT_MCR_RTS 1
`define UFT_MCR_OUT1 2
`define UFT_MCR_OUT2 3
// Receive FIFO level at which the 16th character is arriving
`define UFT_LEVEL_FULL15 5'd15
`endif

/* uft_baud_gen.v */
// Baud generator: divides the system clock into a one-cycle 16x tick.
// Assumes the divisor is static after reset.
`timescale 1ns/1ps
`default_nettype none
module uft_baud_gen #(
  parameter [15:0] DIVISOR = 16'd4
) (
  input wire mclk_i,
  input wire rst_b_i,
  output reg tick_o
);
  reg [15:0] cnt_q;

  // Free-running down counter; tick on terminal count
  always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= 16'h0000;
      tick_o <= 1'b0;
    end else if (cnt_q == 16'h0000) begin
      cnt_q <= DIVISOR - 16'h0001;
      tick_o <= 1'b1;
    end else begin
      cnt_q <= cnt_q - 16'h0001;
      tick_o <= 1'b0;
    end
  end
endmodule // uft_baud_gen
`default_nettype wire

/* uft_flow_timing_asserts.sv */
// Checker: timing relations seen at the ports of uft_flow_timing.
// Assumes BAUD_DIVISOR of 1, so one baud tick is one clock.
`timescale 1ns/1ps
`default_nettype none
module uft_flow_timing_asserts #(
  parameter [15:0] BAUD_DIVISOR = 16'd1
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic thr_write_i,
  input wire logic mcr_write_i,
  input wire logic [3:0] mcr_data_i,
  input wire logic [3:0] modem_in_i,
  input wire logic fifo_enable_bit_i,
  input wire logic auto_rts_en_i,
  input wire logic [1:0] rx_trigger_i,
  input wire logic [4:0] rx_level_i,
  input wire logic rx_byte_done_i,
  input wire logic rx_first_data_bit_i,
  input wire logic serial_out_o,
  input wire logic interrupt_out_o,
  input wire logic tx_dma_request_n_o,
  input wire logic rts_n_o,
  input wire logic dtr_n_o,
  input wire logic out1_n_o,
  input wire logic out2_n_o
);
  logic [7:0] idle_q;
  wire tx_idle = idle_q == 8'hff;
  wire auto_on = fifo_enable_bit_i && auto_rts_en_i;
  wire mcr_rts = mcr_data_i[1];
  wire [4:0] trig_v = rx_trigger_i == 2'b00 ? 5'h01 :
    rx_trigger_i == 2'b01 ? 5'h04 : 5'h08;
  // A long high run means the transmitter is idle; a stop bit is too short
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      idle_q <= 8'h00;
    else if (!serial_out_o)
      idle_q <= 8'h00;
    else if (!tx_idle)
      idle_q <= idle_q + 8'h01;
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  // Start bit: line stays high at least 7 more ticks, then falls by 24
  sequence s_hold_high;
    serial_out_o[*7];
  endsequence
  sequence s_start_bit;
    s_hold_high ##[1:17] !serial_out_o;
  endsequence
  a_start_window: assert property (
    thr_write_i && tx_idle |=> s_start_bit)
    else $error("start bit outside window");
  a_tx_holding_empty_after_start: assert property (
    $fell(serial_out_o) && tx_idle |-> !interrupt_out_o[*8] ##[1:3]
    interrupt_out_o) else $error("holding empty irq off start");
  a_tx_holding_empty_from_write: assert property (
    thr_write_i && tx_idle |-> ##[16:34] interrupt_out_o)
    else $error("holding empty irq off write");
  a_dma_drop: assert property (
    thr_write_i |=> tx_dma_request_n_o)
    else $error("tx dma request not dropped");
  a_dma_return: assert property (
    $fell(serial_out_o) && tx_idle |-> ##[1:9] !tx_dma_request_n_o)
    else $error("tx dma request late");
  a_mcr_direct: assert property (
    mcr_write_i |=> ({out2_n_o, out1_n_o, rts_n_o, dtr_n_o} & 4'hd) ==
    (~$past(mcr_data_i) & 4'hd)) else $error("modem pins wrong");
  a_rts_follow: assert property (
    mcr_write_i && !auto_on |=> rts_n_o == !$past(mcr_rts))
    else $error("rts not following control bit");
  a_modem_irq: assert property (
    $changed(modem_in_i) |-> ##[1:2] interrupt_out_o)
    else $error("modem irq late");
  a_rts_thresh: assert property (
    rx_byte_done_i && auto_on && rx_trigger_i != 2'b11 &&
    rx_level_i + 5'h01 >= trig_v |-> ##[1:2] rts_n_o)
    else $error("rts not raised at threshold");
  a_rts_full: assert property (
    rx_first_data_bit_i && auto_on && rx_trigger_i == 2'b11 &&
    rx_level_i == 5'h0f |-> ##[1:2] rts_n_o) else $error("rts late");
  a_reset_rts: assert property (
    $rose(rst_b_i) |-> rts_n_o && dtr_n_o && serial_out_o)
    else $error("pins not high after reset");
endmodule // uft_flow_timing_asserts
bind uft_flow_timing uft_flow_timing_asserts
  #(.BAUD_DIVISOR(BAUD_DIVISOR)) chk_u (.*);
`default_nettype wire

/* uft_remote_rx.sv */
// Remote serial receiver: rebuilds bytes from the block's serial line.
// Assumes 16 clocks per bit, 8 data bits LSB first, one stop bit.
`timescale 1ns/1ps
`default_nettype none
module uft_remote_rx #(
  parameter int BIT_CLKS = 16
) (
  input wire logic clk_i,
  input wire logic line_i,
  output var logic [7:0] data_o,
  output var logic stop_o,
  output var logic [15:0] frames_o
);
  logic [7:0] sh;
  // Sample mid-bit on the falling edge, clear of line updates
  initial begin
    frames_o = 16'h0000;
    forever begin
      @(negedge line_i);
      repeat (BIT_CLKS / 2) @(negedge clk_i);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CLKS) @(negedge clk_i);
        sh[i] = line_i;
      end
      repeat (BIT_CLKS) @(negedge clk_i);
      stop_o = line_i;
      data_o = sh;
      frames_o = frames_o + 16'h0001;
    end
  end
endmodule // uft_remote_rx
`default_nettype wire

/* uft_flow_timing_bench.sv */
// Testbench: walks the flow-timing block through its timing scenarios.
// Assumes baud divisor 1, so one baud tick per clock.
`timescale 1ns/1ps
`default_nettype none
module uft_flow_timing_bench;
  logic mclk_i, rst_b_i, thr_write_i, iir_read_i, msr_read_i, mcr_write_i;
  logic fifo_enable_bit_i, dma_mode_bit_i, auto_rts_en_i, rx_byte_done_i;
  logic rx_first_data_bit_i, rx_buffer_read_i, rx_data_event_i;
  logic rx_timeout_i, rclk_tick_i;
  logic [7:0] thr_data_i;
  logic [3:0] mcr_data_i, modem_in_i;
  logic [1:0] rx_trigger_i;
  logic [4:0] rx_level_i;
  wire serial_out_o, interrupt_out_o, tx_dma_request_n_o, rx_dma_request_n_o;
  wire rts_n_o, dtr_n_o, out1_n_o, out2_n_o, rx_stop;
  wire [7:0] rx_byte;
  wire [15:0] rx_frames;
  int errors = 0;
  int checks_done = 0;
  uft_flow_timing #(.BAUD_DIVISOR(16'd1)) dut_u (.*);
  uft_remote_rx rx_u (.clk_i(mclk_i), .line_i(serial_out_o),
    .data_o(rx_byte), .stop_o(rx_stop), .frames_o(rx_frames));
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  task automatic step(input int k = 1);
    repeat (k) @(posedge mclk_i);
    #1;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  function automatic logic pick(input int sel);
    case (sel)
      0: return serial_out_o;
      1: return interrupt_out_o;
      2: return rts_n_o;
      default: return tx_dma_request_n_o;
    endcase
  endfunction
  // Counts whole cycles until an output reaches a level, bounded
  task automatic waitf(input int sel, input logic want, output int n);
    n = 0;
    while (pick(sel) !== want && n < 900) begin
      step();
      n++;
    end
  endtask
  task automatic rx_expect(input int c, input logic [7:0] b);
    int k = 0;
    while (rx_frames < c && k < 900) begin
      step();
      k++;
    end
    chk(rx_byte, b);
    chk(rx_stop, 1'b1);
  endtask
  // Two back-to-back bytes: latencies from write and from start bit
  task automatic t_tx;
    int n, d, m;
    thr_data_i = 8'ha5;
    thr_write_i = 1'b1;
    step();
    thr_write_i = 1'b0;
    chk(tx_dma_request_n_o, 1'b1);
    waitf(0, 1'b0, n);
    chk(n >= 8 && n <= 24, 1'b1);
    waitf(3, 1'b0, d);
    chk(d <= 9, 1'b1);
    waitf(1, 1'b1, m);
    chk(d + m >= 8 && d + m <= 10, 1'b1);
    chk(n + d + m >= 16 && n + d + m <= 34, 1'b1);
    thr_data_i = 8'h3c;
    thr_write_i = 1'b1;
    step();
    thr_write_i = 1'b0;
    waitf(1, 1'b0, n);
    chk(n <= 1, 1'b1);
    rx_expect(1, 8'ha5);
    rx_expect(2, 8'h3c);
    waitf(1, 1'b1, n);
    iir_read_i = 1'b1;
    step();
    iir_read_i = 1'b0;
    waitf(1, 1'b0, n);
    chk(n <= 1, 1'b1);
  endtask
  task automatic t_modem;
    int n;
    mcr_data_i = 4'hd;
    mcr_write_i = 1'b1;
    step();
    mcr_write_i = 1'b0;
    chk({out2_n_o, out1_n_o, rts_n_o, dtr_n_o}, 4'h2);
    modem_in_i = 4'h5;
    waitf(1, 1'b1, n);
    chk(n <= 2, 1'b1);
    msr_read_i = 1'b1;
    step();
    msr_read_i = 1'b0;
    waitf(1, 1'b0, n);
    chk(n <= 2, 1'b1);
  endtask
  // Normal event must land on the first reference tick, timeout on ninth
  task automatic t_rxirq;
    int t;
    for (int k = 0; k < 2; k++) begin
      t = 0;
      rx_data_event_i = (k == 0);
      rx_timeout_i = (k == 1);
      step();
      rx_data_event_i = 1'b0;
      rx_timeout_i = 1'b0;
      for (int i = 0; i < 80 && interrupt_out_o !== 1'b1; i++) begin
        rclk_tick_i = (i % 4 == 3);
        step();
        t += int'(rclk_tick_i);
      end
      rclk_tick_i = 1'b0;
      chk(8'(t), k ? 8'h09 : 8'h01);
      rx_buffer_read_i = 1'b1;
      step();
      rx_buffer_read_i = 1'b0;
      step(2);
    end
  endtask
  task automatic t_dma;
    rx_level_i = 5'h02;
    rx_trigger_i = 2'b10;
    for (int k = 0; k < 4; k++) begin
      {dma_mode_bit_i, fifo_enable_bit_i} = 2'(k);
      step(2);
      chk(rx_dma_request_n_o, k == 3);
    end
    {dma_mode_bit_i, fifo_enable_bit_i} = 2'b00;
  endtask
  // Every trigger code: raise at threshold, drop after last byte read
  task automatic t_auto;
    logic [4:0] lv [3] = '{5'h00, 5'h03, 5'h07};
    int n;
    mcr_data_i = 4'h2;
    mcr_write_i = 1'b1;
    step();
    mcr_write_i = 1'b0;
    chk(rts_n_o, 1'b0);
    fifo_enable_bit_i = 1'b1;
    auto_rts_en_i = 1'b1;
    for (int k = 0; k < 4; k++) begin
      rx_trigger_i = 2'(k);
      rx_level_i = k < 3 ? lv[k] : 5'h0f;
      rx_byte_done_i = k < 3;
      rx_first_data_bit_i = k == 3;
      step();
      rx_byte_done_i = 1'b0;
      rx_first_data_bit_i = 1'b0;
      waitf(2, 1'b1, n);
      chk(n <= 2, 1'b1);
      rx_level_i = 5'h01;
      rx_buffer_read_i = 1'b1;
      step();
      rx_buffer_read_i = 1'b0;
      waitf(2, 1'b0, n);
      chk(n <= 2, 1'b1);
    end
    fifo_enable_bit_i = 1'b0;
    rx_trigger_i = 2'b00;
    rx_level_i = 5'h00;
    rx_byte_done_i = 1'b1;
    step();
    rx_byte_done_i = 1'b0;
    step(3);
    chk(rts_n_o, 1'b0);
  endtask
  // Reset in mid-frame with holding-empty pending and RTS active
  task automatic t_reset;
    int n;
    thr_data_i = 8'h81;
    thr_write_i = 1'b1;
    step();
    thr_write_i = 1'b0;
    waitf(1, 1'b1, n);
    chk(serial_out_o, 1'b0);
    rst_b_i = 1'b0;
    step();
    chk({rts_n_o, serial_out_o, interrupt_out_o}, 3'b110);
    rst_b_i = 1'b1;
    step(2);
    chk(interrupt_out_o, 1'b0);
  endtask
  task automatic tally_and_finish;
    if (errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Run should need under a thousand cycles; this limit means a hang
  initial begin
    #400000;
    errors++;
    tally_and_finish();
  end
  initial begin
    {rst_b_i, thr_write_i, iir_read_i, msr_read_i, mcr_write_i} = '0;
    {fifo_enable_bit_i, dma_mode_bit_i, auto_rts_en_i, rx_byte_done_i} = '0;
    {rx_first_data_bit_i, rx_buffer_read_i, rx_data_event_i} = '0;
    {rx_timeout_i, rclk_tick_i, thr_data_i, mcr_data_i} = '0;
    {modem_in_i, rx_trigger_i, rx_level_i} = '0;
    step(5);
    rst_b_i = 1'b1;
    step(300);
    t_tx();
    t_modem();
    t_rxirq();
    t_dma();
    t_auto();
    t_reset();
    tally_and_finish();
  end
endmodule // uft_flow_timing_bench
`default_nettype wire
